/* src/ts_defs.svh */
// Purpose: named constants for the two-wire master sequencer
// Assumes: 125 MHz system clock
// Notes: status codes keep their low three bits at zero
`ifndef TS_DEFS_SVH
`define TS_DEFS_SVH

// register indexes on the plain port
`define TS_CTL_IDX 2'h0
`define TS_STS_IDX 2'h1
`define TS_DAT_IDX 2'h2
`define TS_CTL_MASK 8'h7C
`define TS_CTL_RESET 8'h00

// bus status codes
`define TS_ST_START 8'h08
`define TS_ST_RSTART 8'h10
`define TS_ST_AW_ACK 8'h18
`define TS_ST_AW_NACK 8'h20
`define TS_ST_DT_ACK 8'h28
`define TS_ST_DT_NACK 8'h30
`define TS_ST_LOST 8'h38
`define TS_ST_AR_ACK 8'h40
`define TS_ST_AR_NACK 8'h48
`define TS_ST_DR_ACK 8'h50
`define TS_ST_DR_NACK 8'h58
`define TS_ST_IDLE 8'hF8

// bit slots and phases
`define TS_BIT_FIRST 4'h0
`define TS_BIT_ACK 4'h8
`define TS_PH_FIRST 2'h0
`define TS_PH_HIGH 2'h1
`define TS_PH_LOW 2'h2
`define TS_PH_LAST 2'h3

// timing: one bit is four quarters
`define TS_CLK_NS 8
`define TS_QTR_NS 2500
`define TS_QTR_CYC (`TS_QTR_NS / `TS_CLK_NS)

`endif

/* src/ts_master_seq.sv */
// Purpose: byte-level two-wire bus master with status-code sequencing
// Assumes: software answers each status through control and data registers
// Notes: slave modes and bit-rate selection are absent; one fixed rate
//
// Overview of operation
// - after a start post 08H; software loads address+write, clears flag; it is sent
// - after a repeated start post 10H; address+read switches to master receive
// - address+write acked posts 18H; no start/stop sends the loaded byte
// - in 18H-30H, start set and stop clear issues a repeated start
// - stop set, start clear drives a stop and clears the stop bit
// - stop and start set send stop then start, stop bit cleared
// - address+write not acked posts 20H with the same four choices
// - sent data posts 28H acked or 30H not, same four choices
// - lost arbitration posts 38H; release bus, or start again when free
// - loss during the receive acknowledge also posts 38H and releases
// - address+read acked posts 40H; next byte acked per acknowledge enable
// - address+read not acked posts 48H; repeated start, stop, or both
// - at 50H software reads the byte; next byte acked per enable
// - at 58H software reads the last byte and picks restart or stop
// - address+write after repeated start in receive returns to transmit
// - transfer is held while the flag is set
// - acknowledge enable clear means never entering slave operation
//
// The placing of the registers and the strobed register port are this design's own decisions.
`timescale 1ns/100ps
`include "ts_defs.svh"
`default_nettype none
module ts_master_seq
  import ts_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // register port
  input wire logic [1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // bus clock line
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe_b,
  // bus data line
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_b
);

  // low when driving: drive_low=1 means pull the line down
  function automatic logic bit_drive(input logic [3:0] n, input logic [7:0] sh,
                                     input logic rxd, input logic ackd);
    if (n == `TS_BIT_ACK) begin
      bit_drive = rxd && ackd;
    end else begin
      bit_drive = !rxd && !sh[7];
    end
  endfunction

  ts_pins_type pins_s;
  ts_ctrl_type ctl;
  ts_state_type state;
  logic scl_s, sda_s, scl_d, sda_d;
  logic busy, own_bus, mrx, is_addr, ack_en, got_ack;
  logic [7:0] shift, status;
  logic [3:0] bitn;
  logic [1:0] ph;
  logic [8:0] cnt;

  assign scl_out = 1'b0;
  assign sda_out = 1'b0;

  ts_pins_type pins_raw;
  assign pins_raw = '{scl: scl_in, sda: sda_in};

  ts_sync u_sync (
    .mclk(mclk),
    .rst_b(rst_b),
    .din(pins_raw),
    .dout(pins_s)
  );
  assign scl_s = pins_s.scl;
  assign sda_s = pins_s.sda;

  // bus free tracking from conditions seen on the lines
  wire start_seen = scl_s && scl_d && sda_d && !sda_s;
  wire stop_seen = scl_s && scl_d && !sda_d && sda_s;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
      busy <= 1'b0;
    end else begin
      scl_d <= scl_s;
      sda_d <= sda_s;
      busy <= start_seen || (busy && !stop_seen);
    end
  end

  // quarter-bit timer; a slave stretching the clock stalls it in the high phase
  wire active = state == st_start || state == st_byte || state == st_stop;
  // a busy bus only holds off the first quarter; our own start sets busy and must not stall itself
  wire stall = (ph == `TS_PH_HIGH && !scl_s) || (state == st_start && ph == `TS_PH_FIRST && !own_bus && busy);
  wire tick = active && !stall && cnt == 9'(`TS_QTR_CYC - 1);
  wire last_ph = tick && ph == `TS_PH_LAST;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      cnt <= '0;
    end else if (!active || stall || tick) begin
      cnt <= '0;
    end else begin
      cnt <= cnt + 9'h001;
    end
  end

  // register decode
  wire ctl_wr = reg_wr && reg_addr == `TS_CTL_IDX;
  wire dat_wr = reg_wr && reg_addr == `TS_DAT_IDX && state != st_byte;
  wire [7:0] ctl_word = ctl & `TS_CTL_MASK;
  wire [7:0] rd_mux = reg_addr == `TS_CTL_IDX ? ctl_word :
                      reg_addr == `TS_STS_IDX ? status :
                      reg_addr == `TS_DAT_IDX ? shift : 8'h00;

  // status classes used to choose the next bus action
  wire adr_sts = status inside {`TS_ST_START, `TS_ST_RSTART};
  wire tx_sts = status inside {`TS_ST_AW_ACK, `TS_ST_AW_NACK, `TS_ST_DT_ACK, `TS_ST_DT_NACK};
  wire rx_go = status inside {`TS_ST_AR_ACK, `TS_ST_DR_ACK};
  wire rx_end = status inside {`TS_ST_AR_NACK, `TS_ST_DR_NACK};
  wire lost_sts = status == `TS_ST_LOST;

  // software answers only once the flag is cleared
  wire resume = state == st_wait && !ctl.si;
  wire do_rs = resume && (tx_sts || rx_end) && ctl.start_request_bit && !ctl.stop_request_bit;
  wire do_stop = resume && (tx_sts || rx_end) && ctl.stop_request_bit;
  wire do_byte = resume && (adr_sts || rx_go || (tx_sts && !ctl.start_request_bit && !ctl.stop_request_bit));
  wire lost_rs = resume && lost_sts && ctl.start_request_bit;
  wire go_idle = resume && !do_rs && !do_stop && !do_byte && !lost_rs && !rx_end;
  wire idle_go = state == st_idle && ctl.en && ctl.start_request_bit && !ctl.si;

  // loss: line low while this end released it in a slot it owns
  wire rx_data = mrx && !is_addr;
  wire sending = bitn == `TS_BIT_ACK ? rx_data : !rx_data;
  wire lost = tick && state == st_byte && ph == `TS_PH_HIGH && sending && sda_oe_b && !sda_s;

  wire ack_seen = got_ack;
  wire [7:0] byte_code = is_addr ? (mrx ? (ack_seen ? `TS_ST_AR_ACK : `TS_ST_AR_NACK) :
                                          (ack_seen ? `TS_ST_AW_ACK : `TS_ST_AW_NACK)) :
                         mrx ? (ack_en ? `TS_ST_DR_ACK : `TS_ST_DR_NACK) :
                         (ack_seen ? `TS_ST_DT_ACK : `TS_ST_DT_NACK);
  wire [7:0] post_code = lost ? `TS_ST_LOST :
                         state == st_start ? (own_bus ? `TS_ST_RSTART : `TS_ST_START) : byte_code;
  wire post = lost || (last_ph && (state == st_start || (state == st_byte && bitn == `TS_BIT_ACK)));
  wire stop_done = last_ph && state == st_stop;

  // control: flag set by hardware wins over a software clear in the same cycle
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      ctl <= ts_ctrl_type'(`TS_CTL_RESET);
    end else begin
      if (stop_done) begin
        ctl.stop_request_bit <= 1'b0;
      end
      if (ctl_wr) begin
        ctl <= ts_ctrl_type'(reg_wdata & `TS_CTL_MASK);
      end
      if (post) begin
        ctl.si <= 1'b1;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      status <= `TS_ST_IDLE;
    end else if (post) begin
      status <= post_code;
    end else if (stop_done || go_idle) begin
      status <= `TS_ST_IDLE;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= reg_rd ? rd_mux : 8'h00;
    end
  end

  // byte engine; scl stays low in the wait state, which suspends the transfer, except after a loss, which releases both lines
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      state <= st_idle;
      ph <= `TS_PH_FIRST;
      bitn <= `TS_BIT_FIRST;
      shift <= 8'h00;
      scl_oe_b <= 1'b1;
      sda_oe_b <= 1'b1;
      own_bus <= 1'b0;
      mrx <= 1'b0;
      is_addr <= 1'b0;
      ack_en <= 1'b0;
      got_ack <= 1'b0;
    end else begin
      if (dat_wr) begin
        shift <= reg_wdata;
      end
      if (tick) begin
        ph <= ph + 2'h1;
      end
      case (state)
        st_idle: begin
          scl_oe_b <= 1'b1;
          sda_oe_b <= 1'b1;
          ph <= `TS_PH_FIRST;
          if (idle_go) begin
            state <= st_start;
          end
        end
        st_start: begin
          if (tick && ph == `TS_PH_FIRST) begin
            scl_oe_b <= 1'b1;
          end else if (tick && ph == `TS_PH_HIGH) begin
            sda_oe_b <= 1'b0;
          end else if (tick && ph == `TS_PH_LOW) begin
            scl_oe_b <= 1'b0;
          end else if (last_ph) begin
            own_bus <= 1'b1;
            state <= st_wait;
          end
        end
        st_byte: begin
          if (lost) begin
            // let go of both lines at once; no slave logic follows
            scl_oe_b <= 1'b1;
            sda_oe_b <= 1'b1;
            own_bus <= 1'b0;
            state <= st_wait;
          end else if (tick && ph == `TS_PH_FIRST) begin
            scl_oe_b <= 1'b1;
          end else if (tick && ph == `TS_PH_HIGH) begin
            if (bitn == `TS_BIT_ACK) begin
              got_ack <= !sda_s;
            end else begin
              shift <= {shift[6:0], sda_s};
            end
          end else if (tick && ph == `TS_PH_LOW) begin
            scl_oe_b <= 1'b0;
          end else if (last_ph) begin
            if (bitn == `TS_BIT_ACK) begin
              sda_oe_b <= 1'b1;
              state <= st_wait;
            end else begin
              bitn <= bitn + 4'h1;
              sda_oe_b <= !bit_drive(bitn + 4'h1, shift, rx_data, ack_en);
            end
          end
        end
        st_stop: begin
          if (tick && ph == `TS_PH_FIRST) begin
            scl_oe_b <= 1'b1;
          end else if (tick && ph == `TS_PH_HIGH) begin
            sda_oe_b <= 1'b1;
          end else if (stop_done) begin
            own_bus <= 1'b0;
            state <= ctl.start_request_bit ? st_start : st_idle;
          end
        end
        st_wait: begin
          ph <= `TS_PH_FIRST;
          if (do_byte) begin
            bitn <= `TS_BIT_FIRST;
            state <= st_byte;
            if (adr_sts) begin
              mrx <= shift[0];
              is_addr <= 1'b1;
            end else begin
              is_addr <= 1'b0;
            end
            ack_en <= ctl.aa;
            sda_oe_b <= !bit_drive(`TS_BIT_FIRST, shift, rx_go, ctl.aa);
          end else if (do_rs || lost_rs) begin
            sda_oe_b <= 1'b1;
            state <= st_start;
          end else if (do_stop) begin
            sda_oe_b <= 1'b0;
            state <= st_stop;
          end else if (go_idle) begin
            state <= st_idle;
          end
        end
        default: begin
          state <= st_idle;
        end
      endcase
    end
  end

  default clocking dflt @(posedge mclk);
  endclocking
  default disable iff (!rst_b);

  a_post_sets_flag: assert property (post |=> ctl.si && status == $past(post_code))
    else $error("status and flag not posted together");

  a_code_low_zero: assert property (status[2:0] == 3'h0)
    else $error("status code low bits not zero");

  a_flag_suspends: assert property (ctl.si |-> state == st_wait || state == st_idle)
    else $error("transfer ran while flag set");

  a_start_code: assert property (post && state == st_start && !own_bus |=> status == `TS_ST_START)
    else $error("first start did not post 08H");

  a_rx_switch: assert property (do_byte && adr_sts |=> mrx == $past(shift[0]) && is_addr)
    else $error("direction bit not taken as mode");

  a_rstart_taken: assert property (do_rs |=> state == st_start && sda_oe_b)
    else $error("repeated start not begun");

  a_stop_clears: assert property (stop_done && !ctl_wr |=> !ctl.stop_request_bit)
    else $error("stop bit not cleared after stop");

  a_stop_then_start: assert property (stop_done && ctl.start_request_bit && !ctl_wr |=> state == st_start)
    else $error("start did not follow stop");

  a_lost_code: assert property (lost |-> post_code == `TS_ST_LOST ##1 scl_oe_b && sda_oe_b)
    else $error("loss not posted or bus held");

  a_ack_drive: assert property (state == st_byte && bitn == `TS_BIT_ACK && rx_data && ph == `TS_PH_HIGH
    |-> sda_oe_b == !ack_en)
    else $error("receive acknowledge does not follow enable");

  a_stop_begun: assert property (do_stop |=> state == st_stop && !sda_oe_b)
    else $error("stop not begun with data low");

  a_tx_byte_go: assert property (do_byte && tx_sts |=> state == st_byte && !is_addr)
    else $error("data byte not started");

  a_lost_lets_go: assert property (lost |=> !own_bus && state == st_wait)
    else $error("bus still owned after loss");

  a_idle_released: assert property (state == st_idle |-> scl_oe_b && sda_oe_b)
    else $error("line driven while idle");

endmodule
`default_nettype wire

/* src/ts_pkg.sv */
// Purpose: types shared by the two-wire master sequencer
// Assumes: nothing
// Notes: control struct matches the control register bit layout
package ts_pkg;

  typedef enum logic [2:0] {
    st_idle,
    st_start,
    st_byte,
    st_stop,
    st_wait
  } ts_state_type;

  typedef struct packed {
    logic pad_hi;
    logic en;
    logic start_request_bit;
    logic stop_request_bit;
    logic si;
    logic aa;
    logic [1:0] pad_lo;
  } ts_ctrl_type;

  typedef struct packed {
    logic scl;
    logic sda;
  } ts_pins_type;

endpackage

/* src/ts_sync.sv */
// Purpose: two-stage synchroniser for the bus lines
// Assumes: inputs change freely against mclk
// Notes: first stage feeds only the second stage
`timescale 1ns/100ps
`default_nettype none
module ts_sync
  import ts_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // lines
  input wire ts_pins_type din,
  output ts_pins_type dout
);

  ts_pins_type meta;

  // lines idle high, so reset to high avoids a false start
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      meta <= '1;
      dout <= '1;
    end else begin
      meta <= din;
      dout <= meta;
    end
  end

endmodule
`default_nettype wire

/* test/tb_top.sv */
// Purpose: self-checking bench for the two-wire master sequencer
// Assumes: behavioural target on the far side, pull-ups on both lines
// Notes: a byte costs about 11k cycles at the fixed rate, so the transfer list is short
`timescale 1ns/100ps
`include "ts_defs.svh"
`default_nettype none
module tb_top;
  localparam logic [6:0] TGT = 7'h2A;
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  logic [1:0] reg_addr = 2'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic nack_addr = 1'b0;
  logic nack_data = 1'b0;
  logic stretch = 1'b0;
  logic clash = 1'b0;
  logic [7:0] rd_byte = 8'h00;
  logic [7:0] reg_rdata;
  logic [7:0] last_rx;
  logic scl_oe_b;
  logic sda_oe_b;
  logic scl_out;
  logic sda_out;
  logic scl_hold_b;
  logic sda_hold_b;
  logic [7:0] v;
  logic [7:0] d;
  int failures = 0;
  int total_checks = 0;
  // a driven pin shows its output value; a released one shows the pull-up
  wire logic scl_line = (scl_oe_b | scl_out) & scl_hold_b;
  wire logic sda_line = (sda_oe_b | sda_out) & sda_hold_b;

  ts_master_seq u_ts_master_seq (.mclk(mclk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .scl_in(scl_line), .scl_out(scl_out),
    .scl_oe_b(scl_oe_b), .sda_in(sda_line), .sda_out(sda_out), .sda_oe_b(sda_oe_b));
  ts_slave_model #(.ADDR(TGT)) u_ts_slave_model (.scl(scl_line), .sda(sda_line), .nack_addr(nack_addr),
    .nack_data(nack_data), .stretch(stretch), .clash(clash), .rd_byte(rd_byte),
    .scl_hold_b(scl_hold_b), .sda_hold_b(sda_hold_b), .last_rx(last_rx));

  function automatic logic [7:0] abyte(input logic r);
    return {TGT, r};
  endfunction

  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic wr(input logic [1:0] a, input logic [7:0] w);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= w;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [1:0] a, output logic [7:0] r);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 r = reg_rdata;
  endtask

  task automatic rchk(input string name, input logic [1:0] a, input logic [7:0] exp);
    logic [7:0] r;
    rd(a, r);
    chk(name, r, exp);
  endtask

  // bounded wait on one control bit, polling over the register port
  task automatic poll(input int b, input logic val);
    int n;
    n = 0;
    do begin
      rd(`TS_CTL_IDX, v);
      n++;
    end while (v[b] !== val && n < 20000);
    if (n >= 20000) begin
      failures++;
      summarize();
    end
  endtask

  task automatic step(input logic [7:0] ctl, input logic [7:0] exp);
    wr(`TS_CTL_IDX, ctl);
    poll(3, 1'b1);
    rchk("status", `TS_STS_IDX, exp);
  endtask

  task automatic stop_chk();
    wr(`TS_CTL_IDX, 8'h50);
    poll(4, 1'b0);
    rchk("idle status", `TS_STS_IDX, `TS_ST_IDLE);
    chk("lines", {6'h00, scl_line, sda_line}, 8'h03);
  endtask

  initial begin
    forever #4 mclk = ~mclk;
  end

  initial begin
    d = $urandom(32'h91BC);
    repeat (20) @(posedge mclk);
    rst_b <= 1'b1;
    rchk("ctl reset", `TS_CTL_IDX, `TS_CTL_RESET);
    rchk("sts reset", `TS_STS_IDX, `TS_ST_IDLE);
    rchk("unmapped", 2'h3, 8'h00);
    @(posedge mclk);
    #1 chk("rdata idle", reg_rdata, 8'h00);
    wr(`TS_CTL_IDX, 8'h8B);
    rchk("ctl mask", `TS_CTL_IDX, 8'h8B & `TS_CTL_MASK);
    wr(`TS_STS_IDX, 8'h00);
    rchk("sts read only", `TS_STS_IDX, `TS_ST_IDLE);
    wr(`TS_CTL_IDX, 8'h00);
    $display("test registers done");
    rd_byte <= 8'($urandom);
    stretch <= 1'b1;
    step(8'h64, `TS_ST_START);
    repeat (800) @(posedge mclk);
    chk("held clock", {7'h00, scl_line}, 8'h00);
    rchk("held status", `TS_STS_IDX, `TS_ST_START);
    wr(`TS_DAT_IDX, abyte(1'b0));
    step(8'h44, `TS_ST_AW_ACK);
    d = 8'($urandom);
    wr(`TS_DAT_IDX, d);
    step(8'h44, `TS_ST_DT_ACK);
    chk("sent byte", last_rx, d);
    step(8'h64, `TS_ST_RSTART);
    wr(`TS_DAT_IDX, abyte(1'b1));
    step(8'h44, `TS_ST_AR_ACK);
    step(8'h44, `TS_ST_DR_ACK);
    rchk("rx byte", `TS_DAT_IDX, rd_byte);
    step(8'h40, `TS_ST_DR_NACK);
    rchk("last byte", `TS_DAT_IDX, rd_byte);
    step(8'h60, `TS_ST_RSTART);
    wr(`TS_DAT_IDX, abyte(1'b0));
    step(8'h40, `TS_ST_AW_ACK);
    nack_data <= 1'b1;
    wr(`TS_DAT_IDX, 8'($urandom));
    step(8'h40, `TS_ST_DT_NACK);
    stop_chk();
    $display("test transfer done");
    nack_data <= 1'b0;
    nack_addr <= 1'b1;
    stretch <= 1'($urandom);
    step(8'h64, `TS_ST_START);
    wr(`TS_DAT_IDX, abyte(1'b0));
    step(8'h44, `TS_ST_AW_NACK);
    step(8'h74, `TS_ST_START);
    chk("stop bit", v & 8'h10, 8'h00);
    wr(`TS_DAT_IDX, abyte(1'b1));
    step(8'h44, `TS_ST_AR_NACK);
    stop_chk();
    $display("test refusals done");
    nack_addr <= 1'b0;
    clash <= 1'b1;
    step(8'h64, `TS_ST_START);
    wr(`TS_DAT_IDX, abyte(1'b0));
    step(8'h44, `TS_ST_LOST);
    clash <= 1'b0;
    wr(`TS_CTL_IDX, 8'h40);
    repeat (700) @(posedge mclk);
    rchk("lost idle", `TS_STS_IDX, `TS_ST_IDLE);
    chk("released", {6'h00, scl_line, sda_line}, 8'h03);
    $display("test arbitration done");
    summarize();
  end
endmodule
`default_nettype wire

/* test/ts_slave_model.sv */
// Purpose: behavioural two-wire target on the far side of the sequencer
// Assumes: both lines are wired-and with pull-ups in the bench
// Notes: clash pulls data low from the first address bit to make the master lose arbitration
`timescale 1ns/100ps
`default_nettype none
module ts_slave_model #(
  parameter logic [6:0] ADDR = 7'h2A
) (
  // lines
  input wire logic scl,
  input wire logic sda,
  // behaviour knobs
  input wire logic nack_addr,
  input wire logic nack_data,
  input wire logic stretch,
  input wire logic clash,
  input wire logic [7:0] rd_byte,
  // results
  output logic scl_hold_b,
  output logic sda_hold_b,
  output logic [7:0] last_rx
);
  logic [7:0] sh;
  logic [7:0] tx;
  logic addr_ph;
  logic act;
  logic rd;
  logic go;
  int bitn;

  initial begin
    scl_hold_b = 1'b1;
    sda_hold_b = 1'b1;
    last_rx = 8'h00;
    addr_ph = 1'b0;
    act = 1'b0;
    rd = 1'b0;
    go = 1'b0;
    bitn = 10;
  end

  // start: the first falling clock after it opens bit slot 0
  always @(negedge sda) if (scl) begin
    bitn = -1;
    addr_ph = 1'b1;
    act = 1'b0;
  end
  always @(posedge sda) if (scl) begin
    act = 1'b0;
    addr_ph = 1'b0;
  end

  always @(posedge scl) begin
    if (bitn >= 0 && bitn < 8) sh = {sh[6:0], sda};
    else if (bitn == 8 && rd && !addr_ph) go = !sda;
  end

  always @(negedge scl) begin
    bitn = bitn + 1;
    sda_hold_b = 1'b1;
    if (bitn == 8 && addr_ph) begin
      act = (sh[7:1] == ADDR) && !nack_addr;
      rd = sh[0];
      go = 1'b1;
    end
    if (bitn == 8 && act && !rd && !addr_ph) last_rx = sh;
    if (bitn == 8 && act && (addr_ph || (!rd && !nack_data))) sda_hold_b = 1'b0;
    if (bitn == 9) begin
      bitn = 0;
      addr_ph = 1'b0;
      tx = rd_byte;
    end
    // read data changes only while the clock is low, so it never fakes a start or stop
    if (bitn < 8 && act && rd && go && !addr_ph) sda_hold_b = tx[7 - bitn];
    if (clash && addr_ph && bitn < 8) sda_hold_b = 1'b0;
  end

  // slow answer: hold the clock low past the master's own low time, so the master must wait
  always @(negedge scl) if (stretch) begin
    scl_hold_b = 1'b0;
    #5200;
    scl_hold_b = 1'b1;
  end
  always @(negedge clash) sda_hold_b = 1'b1;
endmodule
`default_nettype wire
